// File: common/stm_consts.svh
`ifndef STM_CONSTS_SVH
`define STM_CONSTS_SVH
// Register indexes, byte address is four times the index
`define STM_IDX_RSVD_A        8'h12
`define STM_IDX_INJECT        8'h13
`define STM_IDX_STCTL         8'h14
`define STM_IDX_VGAIN         8'h15
`define STM_IDX_RSVD_B        8'h16
`define STM_IDX_MONEN         8'h17
`define STM_IDX_MONGAIN       8'h18
`define STM_IDX_V0LIM         8'h19
`define STM_IDX_V1LIM         8'h1a
`define STM_IDX_TLIM          8'h1b
`define STM_IDX_ALM_STAT      8'h30
`define STM_IDX_ALM_CLR       8'h31
`define STM_IDX_ALM_EN        8'h32
// Reset values
`define STM_RST_RSVD_A        8'h00
`define STM_RST_INJECT        8'h00
`define STM_RST_STCTL         8'h00
`define STM_RST_VGAIN         8'h20
`define STM_RST_RSVD_B        8'h18
`define STM_RST_MONEN         8'h0c
`define STM_RST_MONGAIN       8'h80
`define STM_RST_VLIM          8'h62
`define STM_RST_TLIM          8'h62
`define STM_RST_ALM_EN        8'h00
// Field positions
`define STM_TRIG_BIT          7
`define STM_CNT_MSB           6
`define STM_FORCE_MSB         7
`define STM_FORCE_LSB         4
`define STM_ENTRY_BIT         3
`define STM_CLK_MSB           2
`define STM_CLK_LSB           1
`define STM_FAR_BIT           0
`define STM_GAIN_MSB          6
`define STM_MONEN_MSB         3
`define STM_MONEN_LSB         2
`define STM_SEL_MSB           1
`define STM_GAINEN_BIT        7
`define STM_HI_MSB            6
`define STM_HI_LSB            4
`define STM_LO_MSB            2
// Alarm status bit positions
`define STM_ALM_V0_LO         0
`define STM_ALM_V0_HI         1
`define STM_ALM_V1_LO         2
`define STM_ALM_V1_HI         3
`define STM_ALM_INJ_DONE      4
`endif

// File: common/stm_pkg.sv
package stm_pkg;
   typedef enum logic [1:0] {STM_CLK_EXT, STM_CLK_50M, STM_CLK_25M} stm_clk_e;
   typedef enum logic [1:0] {STM_INJ_IDLE, STM_INJ_RUN} stm_inj_e;
endpackage

// File: hw/stm_regs.sv
`timescale 1ns/1ps
`include "stm_consts.svh"
module stm_regs
   import stm_pkg::*;
(
   input  wire logic        pclk,              // Register clock
   input  wire logic        presetn,           // Async reset, active low
   input  wire logic        psel,              // APB select
   input  wire logic        penable,           // APB access phase
   input  wire logic        pwrite,            // APB write
   input  wire logic [11:0] paddr,             // APB byte address
   input  wire logic [31:0] pwdata,            // APB write data
   output logic      [31:0] prdata,            // APB read data
   output logic             pready,            // APB ready
   output logic             pslverr,           // APB error
   input  wire logic [2:0]  chan0_level,       // Ch0 measured level, async
   input  wire logic [2:0]  chan1_level,       // Ch1 measured level, async
   input  wire logic        fwd_parity_slot,   // Link frame parity slot pulse
   output logic             fwd_parity_force,  // Corrupt parity this slot
   output logic             self_test_mode,    // Self-test active
   output stm_clk_e         self_test_clk_select, // Self-test clock source
   output logic             far_self_test_enable, // Far-end self-test enable
   output logic             fwd_force_en,      // Forced errors enabled
   output logic [6:0]       voltage_meas_gain, // Gain divisor, gain=128/value
   output logic             gain_use_en,       // Apply programmed gain
   output logic             monitor_on,        // Sensor powered
   output logic [1:0]       pin_sense_sel,     // Sensed pins
   output logic             irq                // Interrupt, level
);

////////////////////////////////////////////////////////////////////////////////
// Bus decode

   logic [7:0] parity_error_injection;
   logic [7:0] self_test_control;
   logic [7:0] monitor_voltage_gain;
   logic [7:0] reserved_block_a;
   logic [7:0] reserved_block_b;
   logic [7:0] monitor_enable_select;
   logic [7:0] monitor_gain_control;
   logic [7:0] voltage_chan0_limits;
   logic [7:0] voltage_chan1_limits;
   logic [7:0] temperature_limits;
   logic [7:0] alarm_status;
   logic [7:0] alarm_enable;
   logic [7:0] acc_idx;
   logic       wr;
   logic       rd_ok;
   logic [7:0] rd_val;
   logic       inj_done;

   function automatic logic is_reg(input logic [7:0] idx, input logic [7:0] want);
      is_reg = (idx == want);
   endfunction

   assign acc_idx = paddr[9:2];
   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite && !pslverr;

   // Unmapped or misaligned accesses get an error, writes dropped
   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      unique case (acc_idx)
         `STM_IDX_RSVD_A:   rd_val = reserved_block_a;
         `STM_IDX_INJECT:   rd_val = parity_error_injection;
         `STM_IDX_STCTL:    rd_val = self_test_control;
         `STM_IDX_VGAIN:    rd_val = monitor_voltage_gain;
         `STM_IDX_RSVD_B:   rd_val = reserved_block_b;
         `STM_IDX_MONEN:    rd_val = monitor_enable_select;
         `STM_IDX_MONGAIN:  rd_val = monitor_gain_control;
         `STM_IDX_V0LIM:    rd_val = voltage_chan0_limits;
         `STM_IDX_V1LIM:    rd_val = voltage_chan1_limits;
         `STM_IDX_TLIM:     rd_val = temperature_limits;
         `STM_IDX_ALM_STAT: rd_val = alarm_status;
         `STM_IDX_ALM_CLR:  rd_val = 8'h00;
         `STM_IDX_ALM_EN:   rd_val = alarm_enable;
         default:           rd_ok  = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
         rd_ok = 1'b0;
   end

   assign pslverr = psel && penable && !rd_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h00_0000, rd_val};
   end

////////////////////////////////////////////////////////////////////////////////
// Plain read-write registers

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reserved_block_a      <= `STM_RST_RSVD_A;
         self_test_control     <= `STM_RST_STCTL;
         monitor_voltage_gain  <= `STM_RST_VGAIN;
         reserved_block_b      <= `STM_RST_RSVD_B;
         monitor_enable_select <= `STM_RST_MONEN;
         monitor_gain_control  <= `STM_RST_MONGAIN;
         voltage_chan0_limits  <= `STM_RST_VLIM;
         voltage_chan1_limits  <= `STM_RST_VLIM;
         temperature_limits    <= `STM_RST_TLIM;
         alarm_enable          <= `STM_RST_ALM_EN;
      end
      else if (wr)
      begin
         if (is_reg(acc_idx, `STM_IDX_RSVD_A))  reserved_block_a      <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_STCTL))   self_test_control     <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_VGAIN))   monitor_voltage_gain  <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_RSVD_B))  reserved_block_b      <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_MONEN))   monitor_enable_select <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_MONGAIN)) monitor_gain_control  <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_V0LIM))   voltage_chan0_limits  <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_V1LIM))   voltage_chan1_limits  <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_TLIM))    temperature_limits    <= pwdata[7:0];
         if (is_reg(acc_idx, `STM_IDX_ALM_EN))  alarm_enable          <= pwdata[7:0];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Self-test and monitor controls

   assign self_test_mode       = self_test_control[`STM_ENTRY_BIT];
   assign far_self_test_enable = self_test_control[`STM_FAR_BIT];
   assign fwd_force_en = self_test_control[`STM_FORCE_MSB:`STM_FORCE_LSB] != 4'h0;
   assign voltage_meas_gain    = monitor_voltage_gain[`STM_GAIN_MSB:0];
   assign gain_use_en          = monitor_gain_control[`STM_GAINEN_BIT];
   // Partial codes 01/10 treated as off; only 11 powers the sensor
   assign monitor_on = &monitor_enable_select[`STM_MONEN_MSB:`STM_MONEN_LSB];
   assign pin_sense_sel = monitor_enable_select[`STM_SEL_MSB:0];

   always_comb
   begin
      unique case (self_test_control[`STM_CLK_MSB:`STM_CLK_LSB])
         2'h0:    self_test_clk_select = STM_CLK_EXT;
         2'h1:    self_test_clk_select = STM_CLK_50M;
         default: self_test_clk_select = STM_CLK_25M;
      endcase
   end

////////////////////////////////////////////////////////////////////////////////
// Parity error injection

   stm_inj_e   inj_state;
   logic [6:0] inj_left;
   logic       entry_q;
   logic       entry_rise;
   logic       trig_wr;

   assign entry_rise = self_test_mode && !entry_q;
   assign trig_wr    = wr && is_reg(acc_idx, `STM_IDX_INJECT) && pwdata[`STM_TRIG_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         entry_q <= 1'b0;
      else
         entry_q <= self_test_mode;
   end

   // Count field, trigger bit held as the running flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         parity_error_injection <= `STM_RST_INJECT;
      else
      begin
         if (wr && is_reg(acc_idx, `STM_IDX_INJECT))
            parity_error_injection[`STM_CNT_MSB:0] <= pwdata[`STM_CNT_MSB:0];
         if (trig_wr || entry_rise)
            parity_error_injection[`STM_TRIG_BIT] <= 1'b1;
         else if (inj_done)
            parity_error_injection[`STM_TRIG_BIT] <= 1'b0;
      end
   end

   // Each link parity slot while running with errors left takes one error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         inj_state        <= STM_INJ_IDLE;
         inj_left         <= 7'h00;
         fwd_parity_force <= 1'b0;
      end
      else
      begin
         fwd_parity_force <= 1'b0;
         unique case (inj_state)
            STM_INJ_IDLE:
               if (trig_wr || entry_rise)
               begin
                  inj_left  <= trig_wr ? pwdata[`STM_CNT_MSB:0]
                                       : parity_error_injection[`STM_CNT_MSB:0];
                  inj_state <= STM_INJ_RUN;
               end
            STM_INJ_RUN:
               if (inj_left == 7'h00)
                  inj_state <= STM_INJ_IDLE;
               else if (fwd_parity_slot)
               begin
                  fwd_parity_force <= 1'b1;
                  inj_left         <= inj_left - 7'h01;
               end
         endcase
      end
   end

   assign inj_done = (inj_state == STM_INJ_RUN) && (inj_left == 7'h00);

////////////////////////////////////////////////////////////////////////////////
// Voltage alarms

   logic [2:0] c0_meta;
   logic [2:0] c0_sync;
   logic [2:0] c1_meta;
   logic [2:0] c1_sync;
   logic [3:0] alarm_hit;
   logic [7:0] alarm_evt;
   logic [7:0] alarm_clr;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c0_meta <= 3'h0;
         c0_sync <= 3'h0;
         c1_meta <= 3'h0;
         c1_sync <= 3'h0;
      end
      else
      begin
         c0_meta <= chan0_level;
         c0_sync <= c0_meta;
         c1_meta <= chan1_level;
         c1_sync <= c1_meta;
      end
   end

   // Unselected channel or disabled monitor raises nothing
   always_comb
   begin
      alarm_hit = 4'h0;
      if (monitor_on && pin_sense_sel[0])
      begin
         alarm_hit[`STM_ALM_V0_HI] = c0_sync > voltage_chan0_limits[`STM_HI_MSB:`STM_HI_LSB];
         alarm_hit[`STM_ALM_V0_LO] = c0_sync < voltage_chan0_limits[`STM_LO_MSB:0];
      end
      if (monitor_on && pin_sense_sel[1])
      begin
         alarm_hit[`STM_ALM_V1_HI] = c1_sync > voltage_chan1_limits[`STM_HI_MSB:`STM_HI_LSB];
         alarm_hit[`STM_ALM_V1_LO] = c1_sync < voltage_chan1_limits[`STM_LO_MSB:0];
      end
   end

   assign alarm_evt = {3'h0, inj_done, alarm_hit};
   assign alarm_clr = (wr && is_reg(acc_idx, `STM_IDX_ALM_CLR)) ? pwdata[7:0] : 8'h00;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_alarm
         // Set wins over a same-cycle clear
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               alarm_status[gi] <= 1'b0;
            else if (alarm_evt[gi])
               alarm_status[gi] <= 1'b1;
            else if (alarm_clr[gi])
               alarm_status[gi] <= 1'b0;
         end
      end
   endgenerate

   assign irq = |(alarm_status & alarm_enable);

endmodule // stm_regs

// File: bench/stm_link_model.sv
`timescale 1ns/1ps
module stm_link_model
(
   input  wire logic       pclk,             // Register clock
   input  wire logic       presetn,          // Async reset, active low
   input  wire logic       fwd_parity_force, // Parity corruption request
   output logic            fwd_parity_slot,  // Parity opportunity pulse
   output logic [7:0]      n_forced          // Corrupted frames seen
);
   logic [1:0] phase;
////////////////////////////////////////
   // One parity opportunity every four cycles, like a short frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase           <= 2'h0;
         fwd_parity_slot <= 1'b0;
      end
      else
      begin
         phase           <= phase + 2'h1;
         fwd_parity_slot <= (phase == 2'h3);
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         n_forced <= 8'h00;
      else if (fwd_parity_force)
         n_forced <= n_forced + 8'h01;
   end
endmodule // stm_link_model

// File: bench/stm_regs_sva.sv
`timescale 1ns/1ps
module stm_regs_sva
   import stm_pkg::*;
(
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        pready, pslverr,
   input wire logic [2:0]  chan0_level, chan1_level,
   input wire logic        fwd_parity_slot, fwd_parity_force, self_test_mode,
   input stm_clk_e         self_test_clk_select,
   input wire logic        far_self_test_enable, fwd_force_en,
   input wire logic [6:0]  voltage_meas_gain,
   input wire logic        gain_use_en, monitor_on,
   input wire logic [1:0]  pin_sense_sel,
   input wire logic        irq
);
   logic wr_ok;
   assign wr_ok = psel & penable & pwrite & ~pslverr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
////////////////////////////////////////
   property p_force_slot; fwd_parity_force |-> $past(fwd_parity_slot); endproperty
   a_force_slot: assert property (p_force_slot) else $error("force without slot");
   property p_entry; wr_ok && paddr == 12'h050 |=> self_test_mode == $past(pwdata[3]); endproperty
   a_entry: assert property (p_entry) else $error("self test entry wrong");
   property p_far; wr_ok && paddr == 12'h050 |=> far_self_test_enable == $past(pwdata[0]); endproperty
   a_far: assert property (p_far) else $error("far enable wrong");
   property p_force_en; wr_ok && paddr == 12'h050 |=> fwd_force_en == ($past(pwdata[7:4]) != 4'h0); endproperty
   a_force_en: assert property (p_force_en) else $error("force enable wrong");
   property p_clk;
      wr_ok && paddr == 12'h050 |=> self_test_clk_select == ($past(pwdata[2]) ? 2'h2 : {1'b0, $past(pwdata[1])});
   endproperty
   a_clk: assert property (p_clk) else $error("clock select wrong");
   property p_gain; wr_ok && paddr == 12'h054 |=> voltage_meas_gain == $past(pwdata[6:0]); endproperty
   a_gain: assert property (p_gain) else $error("gain wrong");
   property p_mon; wr_ok && paddr == 12'h05c |=> monitor_on == ($past(pwdata[3:2]) == 2'h3); endproperty
   a_mon: assert property (p_mon) else $error("monitor enable wrong");
   property p_sel; wr_ok && paddr == 12'h05c |=> pin_sense_sel == $past(pwdata[1:0]); endproperty
   a_sel: assert property (p_sel) else $error("pin select wrong");
   property p_gain_en; wr_ok && paddr == 12'h060 |=> gain_use_en == $past(pwdata[7]); endproperty
   a_gain_en: assert property (p_gain_en) else $error("gain use wrong");
   property p_unmapped; psel && penable && paddr == 12'h100 |-> pslverr && pready; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
endmodule // stm_regs_sva
bind stm_regs stm_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chan0_level(chan0_level), .chan1_level(chan1_level), .fwd_parity_slot(fwd_parity_slot),
   .fwd_parity_force(fwd_parity_force), .self_test_mode(self_test_mode),
   .self_test_clk_select(self_test_clk_select), .far_self_test_enable(far_self_test_enable),
   .fwd_force_en(fwd_force_en), .voltage_meas_gain(voltage_meas_gain), .gain_use_en(gain_use_en),
   .monitor_on(monitor_on), .pin_sense_sel(pin_sense_sel), .irq(irq));

// File: bench/test_stm_regs.sv
`timescale 1ns/1ps
module test_stm_regs
   import stm_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fwd_parity_slot, fwd_parity_force;
   logic        self_test_mode, far_self_test_enable, fwd_force_en, gain_use_en, monitor_on, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0]  chan0_level, chan1_level;
   logic [6:0]  voltage_meas_gain;
   logic [1:0]  pin_sense_sel;
   stm_clk_e    self_test_clk_select;
   logic [7:0]  n_forced;
   int          n_fail, checks_done, k;
   logic [7:0]  idx [11] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h32};
   logic [7:0]  rst [11] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h18, 8'h0c, 8'h80, 8'h62, 8'h62, 8'h62, 8'h00};
   stm_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan0_level(chan0_level), .chan1_level(chan1_level), .fwd_parity_slot(fwd_parity_slot),
      .fwd_parity_force(fwd_parity_force), .self_test_mode(self_test_mode),
      .self_test_clk_select(self_test_clk_select), .far_self_test_enable(far_self_test_enable),
      .fwd_force_en(fwd_force_en), .voltage_meas_gain(voltage_meas_gain), .gain_use_en(gain_use_en),
      .monitor_on(monitor_on), .pin_sense_sel(pin_sense_sel), .irq(irq));
   stm_link_model link (.pclk(pclk), .presetn(presetn), .fwd_parity_force(fwd_parity_force),
      .fwd_parity_slot(fwd_parity_slot), .n_forced(n_forced));
////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      checks_done++;
      if (s !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Starts one edge after the last release so psel is never assigned twice at once
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'h0, i, 2'h0};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         n_fail++;
         tally_and_finish();
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      xfer(1'b1, i, d);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e, input string nm);
      xfer(1'b0, i, 8'h00);
      chk(q, {24'h0, e}, nm);
   endtask
////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      #500us;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
      chan0_level = 3'h4; chan1_level = 3'h4;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 0; k < 11; k++) rd(idx[k], rst[k], "reset value");
      chk({gain_use_en, monitor_on, voltage_meas_gain}, 32'h1a0, "reset outputs");
      for (k = 0; k < 11; k++)
         if (k != 1 && k != 2)
         begin
            wr(idx[k], 8'ha5);
            rd(idx[k], 8'ha5, "readback");
            wr(idx[k], rst[k]);
         end
      wr(8'h15, 8'h40); chk(voltage_meas_gain, 32'h40, "gain");
      wr(8'h18, 8'h00); chk(gain_use_en, 32'h0, "gain use");
      for (k = 0; k < 4; k++)
      begin
         wr(8'h14, {5'h0, k[1:0], 1'b1});
         chk(self_test_clk_select, k > 1 ? 32'h2 : 32'(k), "clock select");
         chk(far_self_test_enable, 32'h1, "far enable");
      end
      wr(8'h14, 8'h90);
      chk({self_test_mode, fwd_force_en, far_self_test_enable}, 32'h2, "force field");
      wr(8'h14, 8'h00); chk(fwd_force_en, 32'h0, "force off");
      for (k = 0; k < 4; k++)
      begin
         wr(8'h17, {4'h0, k[1:0], 2'h0});
         chk(monitor_on, 32'(k == 3), "monitor on");
      end
      // Out of range levels must stay silent while no pin is sensed
      chan0_level <= 3'h7; chan1_level <= 3'h0;
      repeat (5) @(posedge pclk);
      rd(8'h30, 8'h00, "alarms unselected");
      wr(8'h17, 8'h0f); chk(pin_sense_sel, 32'h3, "pin select");
      repeat (5) @(posedge pclk);
      rd(8'h30, 8'h06, "alarms ch0 hi ch1 lo");
      chk(irq, 32'h0, "irq masked");
      wr(8'h32, 8'h02); chk(irq, 32'h1, "irq raised");
      chan0_level <= 3'h1; chan1_level <= 3'h7;
      repeat (5) @(posedge pclk);
      rd(8'h30, 8'h0f, "alarms sticky all");
      chan0_level <= 3'h4; chan1_level <= 3'h4;
      repeat (5) @(posedge pclk);
      wr(8'h31, 8'h0f); rd(8'h30, 8'h00, "alarms cleared");
      chk(irq, 32'h0, "irq cleared");
      wr(8'h32, 8'h00);
      wr(8'h13, 8'h83);
      for (k = 0; k < 50; k++)
      begin
         xfer(1'b0, 8'h13, 8'h00);
         if (q[7] === 1'b0)
            break;
      end
      chk(q, 32'h03, "trigger self clear");
      chk(n_forced, 32'h3, "forced count");
      rd(8'h30, 8'h10, "injection done");
      wr(8'h13, 8'h80); repeat (3) @(posedge pclk);
      rd(8'h13, 8'h00, "zero count clear");
      wr(8'h13, 8'h02); wr(8'h14, 8'h08);
      chk(self_test_mode, 32'h1, "self test mode");
      for (k = 0; k < 100 && n_forced !== 8'h05; k++) @(posedge pclk);
      chk(n_forced, 32'h5, "self test errors");
      xfer(1'b0, 8'h40, 8'h00);
      chk(q, 32'h0, "unmapped read data");
      chk(err, 32'h1, "unmapped read error");
      tally_and_finish();
   end
endmodule // test_stm_regs
